// ===== hdl/tmr8_defines.vh
// constants for the 8-bit dual compare pwm timer
// Summary of operation
// - counter and compare registers are 8 bits
// - bottom is 0x00, max is 0xFF
// - top is 0xFF or compare A
// - clock select zero stops the counter
// - tick from prescaler or external edge
// - each tick clears, increments or decrements
// - cpu reads and writes counter anytime
// - cpu counter write beats count or clear
// - three-bit waveform mode split over controls
// - overflow flag set per mode
// - continuous equality compare for A and B
// - match sets flag one tick later
// - flag cleared by service or write one
// - flags in one register, masks in another
// - compare double buffered in pwm modes
// - buffer transfer only at top or bottom
// - cpu compare access hits buffer when buffered
// - force strobe updates output only, non-pwm
// - counter write blocks next tick match
// - output states kept across mode change
// - compare output mode takes effect immediately
// - module runs only with power-off bit clear
// - normal mode wraps, overflow at zero
// - mode 2 clears on compare A match
// - fast pwm modes 3 and 7
// - output mode zero leaves output unchanged
`ifndef TMR8_DEFINES_VH
`define TMR8_DEFINES_VH
`define TMR8_BOTTOM      8'h00
`define TMR8_MAX         8'hff
`define TMR8_RST8        8'h00
`define TMR8_WGM_NORMAL  3'h0
`define TMR8_WGM_PCPWM   3'h1
`define TMR8_WGM_CTC     3'h2
`define TMR8_WGM_FAST    3'h3
`define TMR8_WGM_PCPWM_A 3'h5
`define TMR8_WGM_FAST_A  3'h7
`define TMR8_CS_STOP     3'h0
`define TMR8_CS_DIV1     3'h1
`define TMR8_CS_DIV8     3'h2
`define TMR8_CS_DIV64    3'h3
`define TMR8_CS_DIV256   3'h4
`define TMR8_CS_DIV1024  3'h5
`define TMR8_CS_EXT_FALL 3'h6
`define TMR8_CS_EXT_RISE 3'h7
`define TMR8_FLAG_OVF    0
`define TMR8_FLAG_MA     1
`define TMR8_FLAG_MB     2
`endif

// ===== hdl/tmr8_tick_gen.v
// timer tick source: prescaler or external count input edge
`timescale 1ns/1ps
`include "tmr8_defines.vh"
module tmr8_tick_gen (
   input  wire       clk_in,      // system clock
   input  wire       rstn_in,     // sync reset, active low
   input  wire       run_in,      // module powered
   input  wire [2:0] cs_in,       // clock source select
   input  wire       ext_in,      // external count input, synchronous
   output reg        tick_out     // one-cycle timer tick
);
   reg [9:0] pre_r;
   reg       ext_r;
   reg       tick_nxt;

   // free prescaler plus edge history of the external input
   always @(posedge clk_in) begin
      if (!rstn_in) begin
         pre_r <= 10'h000;
         ext_r <= 1'b0;
      end else begin
         pre_r <= run_in ? pre_r + 10'h001 : 10'h000;
         ext_r <= ext_in;
      end
   end

   // pick the tick; stop and power-off give no tick at all
   always @* begin
      case (cs_in)
         `TMR8_CS_DIV1:     tick_nxt = 1'b1;
         `TMR8_CS_DIV8:     tick_nxt = (pre_r[2:0] == 3'h7);
         `TMR8_CS_DIV64:    tick_nxt = (pre_r[5:0] == 6'h3f);
         `TMR8_CS_DIV256:   tick_nxt = (pre_r[7:0] == 8'hff);
         `TMR8_CS_DIV1024:  tick_nxt = (pre_r == 10'h3ff);
         `TMR8_CS_EXT_FALL: tick_nxt = ext_r & ~ext_in;
         `TMR8_CS_EXT_RISE: tick_nxt = ~ext_r & ext_in;
         default:           tick_nxt = 1'b0;
      endcase
   end

   always @(posedge clk_in) begin
      if (!rstn_in)
         tick_out <= 1'b0;
      else
         tick_out <= run_in & tick_nxt;
   end
endmodule // tmr8_tick_gen

// ===== hdl/tmr8_out_unit.v
// one output compare state register with its waveform actions
`timescale 1ns/1ps
`include "tmr8_defines.vh"
module tmr8_out_unit (
   input  wire       clk_in,      // system clock
   input  wire       rstn_in,     // sync reset, active low
   input  wire [1:0] com_in,      // compare output mode
   input  wire       pwm_in,      // fast pwm mode active
   input  wire       match_in,    // qualified match on a tick
   input  wire       bottom_in,   // counter restarts at bottom on a tick
   input  wire       force_in,    // force strobe, non-pwm only
   output reg        oc_out       // output compare state
);
   reg oc_nxt;

   // com is read live, so a change applies at the next event
   always @* begin
      oc_nxt = oc_out;
      if (!pwm_in) begin
         if (match_in | force_in) begin
            case (com_in)
               2'h1:    oc_nxt = ~oc_out;
               2'h2:    oc_nxt = 1'b0;
               2'h3:    oc_nxt = 1'b1;
               default: oc_nxt = oc_out;
            endcase
         end
      end else if (com_in[1]) begin
         // inverting mode sets on match, clears at bottom
         if (match_in)
            oc_nxt = com_in[0];
         else if (bottom_in)
            oc_nxt = ~com_in[0];
      end
   end

   always @(posedge clk_in) begin
      if (!rstn_in)
         oc_out <= 1'b0;
      else
         oc_out <= oc_nxt;
   end
endmodule // tmr8_out_unit

// ===== hdl/tmr8_timer.v
// 8-bit timer/counter with two compare units, top module
`timescale 1ns/1ps
`include "tmr8_defines.vh"
module tmr8_timer (
   input  wire       REF_CLK_IN,         // 40 mhz system clock
   input  wire       RSTN_IN,            // sync reset, active low
   input  wire       POWER_OFF_BIT_IN,   // timer power-off bit, 1 halts
   input  wire [1:0] WGM_LOW_IN,         // waveform mode bits 1:0, control a
   input  wire       WGM_HIGH_IN,        // waveform mode bit 2, control b
   input  wire [2:0] CLOCK_SOURCE_IN,    // clock source select, control b
   input  wire [1:0] COM_A_IN,           // compare output mode a
   input  wire [1:0] COM_B_IN,           // compare output mode b
   input  wire       FORCE_A_IN,         // force compare strobe a
   input  wire       FORCE_B_IN,         // force compare strobe b
   input  wire       EXT_COUNT_IN,       // external count input pin
   input  wire       CNT_WR_IN,          // counter write strobe
   input  wire       CMPA_WR_IN,         // compare a write strobe
   input  wire       CMPB_WR_IN,         // compare b write strobe
   input  wire [7:0] WDATA_IN,           // write data
   input  wire [2:0] FLAG_CLR_IN,        // write one to clear flags
   input  wire [2:0] IRQ_ACK_IN,         // interrupt serviced, clears flag
   input  wire [2:0] MASK_WR_DATA_IN,    // new interrupt mask
   input  wire       MASK_WR_IN,         // mask write strobe
   output reg  [7:0] COUNT_VALUE_OUT,    // counter value
   output reg  [7:0] COMPARE_A_OUT,      // compare a as cpu sees it
   output reg  [7:0] COMPARE_B_OUT,      // compare b as cpu sees it
   output reg  [2:0] IRQ_FLAGS_OUT,      // overflow, match a, match b
   output reg  [2:0] IRQ_MASK_OUT,       // interrupt mask
   output reg  [2:0] IRQ_REQ_OUT,        // masked interrupt requests
   output reg        AT_MAX_OUT,         // counter at max
   output reg        AT_BOTTOM_OUT,      // counter at bottom
   output reg        COMPARE_OUT_A_OUT,  // output compare state a
   output reg        COMPARE_OUT_B_OUT,  // output compare state b
   output reg        PIN_OVERRIDE_A_OUT, // output a overrides port
   output reg        PIN_OVERRIDE_B_OUT  // output b overrides port
);
   reg  [7:0] count_value_r;
   reg  [7:0] count_nxt;
   reg  [7:0] compare_value_a_r;         // active compare a
   reg  [7:0] compare_value_b_r;
   reg  [7:0] buf_a_r;                   // buffer registers
   reg  [7:0] buf_b_r;
   reg  [2:0] flags_r;
   reg  [2:0] flags_nxt;
   reg  [2:0] mask_r;
   reg        block_r;                   // counter write blocks next tick
   reg        down_r;                    // phase correct direction
   reg        ovf_set;
   wire [2:0] waveform_mode;
   wire       timer_tick;
   wire       run;
   wire       pwm_mode;
   wire       fast_mode;
   wire       pc_mode;
   wire [7:0] top_val;
   wire       at_top;
   wire       eq_a;
   wire       eq_b;
   wire       match_a;
   wire       match_b;
   wire       restart;
   wire       oc_a;
   wire       oc_b;

   // returns 1 when mode uses compare a as top
   function top_is_a;
      input [2:0] m;
      begin
         top_is_a = (m == `TMR8_WGM_CTC) || (m == `TMR8_WGM_FAST_A) ||
                    (m == `TMR8_WGM_PCPWM_A);
      end
   endfunction

   assign run           = ~POWER_OFF_BIT_IN;
   assign waveform_mode = {WGM_HIGH_IN, WGM_LOW_IN};
   assign fast_mode     = (waveform_mode == `TMR8_WGM_FAST) ||
                          (waveform_mode == `TMR8_WGM_FAST_A);
   assign pc_mode       = (waveform_mode == `TMR8_WGM_PCPWM) ||
                          (waveform_mode == `TMR8_WGM_PCPWM_A);
   assign pwm_mode      = fast_mode | pc_mode;
   assign top_val       = top_is_a(waveform_mode) ? compare_value_a_r
                                                  : `TMR8_MAX;
   assign at_top        = (count_value_r == top_val);
   // comparator runs on every cycle, qualified by tick and block
   assign eq_a          = (count_value_r == compare_value_a_r);
   assign eq_b          = (count_value_r == compare_value_b_r);
   assign match_a       = timer_tick & eq_a & ~block_r & ~CNT_WR_IN;
   assign match_b       = timer_tick & eq_b & ~block_r & ~CNT_WR_IN;
   // a counter write discards the restart, so the bottom action goes too
   assign restart       = timer_tick & fast_mode & at_top & ~CNT_WR_IN;

   tmr8_tick_gen u_tick (
      .clk_in   (REF_CLK_IN),
      .rstn_in  (RSTN_IN),
      .run_in   (run),
      .cs_in    (CLOCK_SOURCE_IN),
      .ext_in   (EXT_COUNT_IN),
      .tick_out (timer_tick)
   );

   // next count: cpu write first, then mode sequence on a tick
   always @* begin
      count_nxt = count_value_r;
      ovf_set   = 1'b0;
      if (CNT_WR_IN) begin
         count_nxt = WDATA_IN;
      end else if (timer_tick) begin
         case (waveform_mode)
            `TMR8_WGM_CTC: begin
               if (eq_a)
                  count_nxt = `TMR8_BOTTOM;
               else
                  count_nxt = count_value_r + 8'h01;
               ovf_set = (count_value_r == `TMR8_MAX);
            end
            `TMR8_WGM_FAST, `TMR8_WGM_FAST_A: begin
               count_nxt = at_top ? `TMR8_BOTTOM : count_value_r + 8'h01;
               ovf_set   = at_top;
            end
            `TMR8_WGM_PCPWM, `TMR8_WGM_PCPWM_A: begin
               // dual slope: overflow marks the turn at bottom
               if (down_r)
                  count_nxt = count_value_r - 8'h01;
               else
                  count_nxt = count_value_r + 8'h01;
               if (at_top && !down_r)
                  count_nxt = count_value_r - 8'h01;
               if (count_value_r == `TMR8_BOTTOM && down_r)
                  count_nxt = count_value_r + 8'h01;
               ovf_set = (count_value_r == `TMR8_BOTTOM) && down_r;
            end
            default: begin
               count_nxt = count_value_r + 8'h01;
               ovf_set   = (count_value_r == `TMR8_MAX);
            end
         endcase
      end
   end

   // counter, direction and blocking state
   always @(posedge REF_CLK_IN) begin
      if (!RSTN_IN) begin
         count_value_r <= `TMR8_RST8;
         down_r        <= 1'b0;
         block_r       <= 1'b0;
      end else begin
         count_value_r <= count_nxt;
         // block survives until the next tick consumes it
         if (CNT_WR_IN)
            block_r <= 1'b1;
         else if (timer_tick)
            block_r <= 1'b0;
         if (!pc_mode)
            down_r <= 1'b0;
         else if (timer_tick && !CNT_WR_IN) begin
            if (at_top)
               down_r <= 1'b1;
            else if (count_value_r == `TMR8_BOTTOM)
               down_r <= 1'b0;
         end
      end
   end

   // compare registers: direct when unbuffered, buffer when pwm
   always @(posedge REF_CLK_IN) begin
      if (!RSTN_IN) begin
         compare_value_a_r <= `TMR8_RST8;
         compare_value_b_r <= `TMR8_RST8;
         buf_a_r           <= `TMR8_RST8;
         buf_b_r           <= `TMR8_RST8;
      end else begin
         if (CMPA_WR_IN)
            buf_a_r <= WDATA_IN;
         if (CMPB_WR_IN)
            buf_b_r <= WDATA_IN;
         if (!pwm_mode) begin
            if (CMPA_WR_IN)
               compare_value_a_r <= WDATA_IN;
            if (CMPB_WR_IN)
               compare_value_b_r <= WDATA_IN;
         end else if (timer_tick &&
                      ((fast_mode && at_top) ||
                       (pc_mode && at_top && !down_r))) begin
            // update at top keeps pwm pulses glitch free
            compare_value_a_r <= buf_a_r;
            compare_value_b_r <= buf_b_r;
         end
      end
   end

   // flags: a hardware set in the same cycle as a clear wins
   always @* begin
      flags_nxt = flags_r & ~(FLAG_CLR_IN | IRQ_ACK_IN);
      if (ovf_set)
         flags_nxt[`TMR8_FLAG_OVF] = 1'b1;
      if (match_a)
         flags_nxt[`TMR8_FLAG_MA] = 1'b1;
      if (match_b)
         flags_nxt[`TMR8_FLAG_MB] = 1'b1;
   end

   always @(posedge REF_CLK_IN) begin
      if (!RSTN_IN) begin
         flags_r <= 3'h0;
         mask_r  <= 3'h0;
      end else begin
         flags_r <= flags_nxt;
         if (MASK_WR_IN)
            mask_r <= MASK_WR_DATA_IN;
      end
   end

   tmr8_out_unit u_out_a (
      .clk_in    (REF_CLK_IN),
      .rstn_in   (RSTN_IN),
      .com_in    (COM_A_IN),
      .pwm_in    (fast_mode),
      .match_in  (match_a),
      .bottom_in (restart),
      .force_in  (FORCE_A_IN & ~pwm_mode),
      .oc_out    (oc_a)
   );

   tmr8_out_unit u_out_b (
      .clk_in    (REF_CLK_IN),
      .rstn_in   (RSTN_IN),
      .com_in    (COM_B_IN),
      .pwm_in    (fast_mode),
      .match_in  (match_b),
      .bottom_in (restart),
      .force_in  (FORCE_B_IN & ~pwm_mode),
      .oc_out    (oc_b)
   );

   // registered view of the internal state
   always @(posedge REF_CLK_IN) begin
      if (!RSTN_IN) begin
         COUNT_VALUE_OUT    <= 8'h00;
         COMPARE_A_OUT      <= 8'h00;
         COMPARE_B_OUT      <= 8'h00;
         IRQ_FLAGS_OUT      <= 3'h0;
         IRQ_MASK_OUT       <= 3'h0;
         IRQ_REQ_OUT        <= 3'h0;
         AT_MAX_OUT         <= 1'b0;
         AT_BOTTOM_OUT      <= 1'b0;
         COMPARE_OUT_A_OUT  <= 1'b0;
         COMPARE_OUT_B_OUT  <= 1'b0;
         PIN_OVERRIDE_A_OUT <= 1'b0;
         PIN_OVERRIDE_B_OUT <= 1'b0;
      end else begin
         COUNT_VALUE_OUT    <= count_nxt;
         COMPARE_A_OUT      <= pwm_mode ? buf_a_r : compare_value_a_r;
         COMPARE_B_OUT      <= pwm_mode ? buf_b_r : compare_value_b_r;
         IRQ_FLAGS_OUT      <= flags_nxt;
         IRQ_MASK_OUT       <= MASK_WR_IN ? MASK_WR_DATA_IN : mask_r;
         IRQ_REQ_OUT        <= flags_nxt & (MASK_WR_IN ? MASK_WR_DATA_IN : mask_r);
         AT_MAX_OUT         <= (count_nxt == `TMR8_MAX);
         AT_BOTTOM_OUT      <= (count_nxt == `TMR8_BOTTOM);
         COMPARE_OUT_A_OUT  <= oc_a;
         COMPARE_OUT_B_OUT  <= oc_b;
         PIN_OVERRIDE_A_OUT <= |COM_A_IN;
         PIN_OVERRIDE_B_OUT <= |COM_B_IN;
      end
   end
endmodule // tmr8_timer

// ===== testbench/tmr8_timer_assertions.sv
// port-level concurrent checks for the 8-bit dual compare timer
`timescale 1ns/1ps
module tmr8_checker (
   input logic       REF_CLK_IN,         // clock
   input logic       RSTN_IN,            // reset, low
   input logic       POWER_OFF_BIT_IN,   // power-off
   input logic [1:0] WGM_LOW_IN,         // mode 1:0
   input logic       WGM_HIGH_IN,        // mode 2
   input logic [2:0] CLOCK_SOURCE_IN,    // source
   input logic [1:0] COM_A_IN,           // output mode a
   input logic       CNT_WR_IN,          // counter write
   input logic [7:0] WDATA_IN,           // write data
   input logic [2:0] FLAG_CLR_IN,        // flag clear
   input logic [2:0] IRQ_ACK_IN,         // serviced
   input logic [2:0] MASK_WR_DATA_IN,    // mask data
   input logic       MASK_WR_IN,         // mask write
   input logic [7:0] COUNT_VALUE_OUT,    // counter
   input logic [2:0] IRQ_FLAGS_OUT,      // flags
   input logic [2:0] IRQ_MASK_OUT,       // mask
   input logic [2:0] IRQ_REQ_OUT,        // requests
   input logic       AT_MAX_OUT,         // at max
   input logic       AT_BOTTOM_OUT,      // at bottom
   input logic       PIN_OVERRIDE_A_OUT  // override a
);
   default clocking cb @(posedge REF_CLK_IN); endclocking
   default disable iff (!RSTN_IN);
   // a tick lands one cycle after its source, so idle must hold two samples
   wire idle = (CLOCK_SOURCE_IN == 3'h0) || POWER_OFF_BIT_IN;
   AST_WRITE_WINS: assert property (CNT_WR_IN |=> COUNT_VALUE_OUT == $past(WDATA_IN))
      else $error("counter write not taken");
   AST_STOP_HOLDS: assert property (
      (CLOCK_SOURCE_IN == 3'h0 && $past(CLOCK_SOURCE_IN) == 3'h0 && !CNT_WR_IN)
      |=> $stable(COUNT_VALUE_OUT)) else $error("stopped counter moved");
   AST_POWER_HOLDS: assert property (
      (POWER_OFF_BIT_IN && $past(POWER_OFF_BIT_IN) && !CNT_WR_IN)
      |=> $stable(COUNT_VALUE_OUT)) else $error("powered-off counter moved");
   AST_AT_BOTTOM: assert property (
      $past(RSTN_IN) |-> AT_BOTTOM_OUT == (COUNT_VALUE_OUT == 8'h00))
      else $error("bottom flag wrong");
   AST_AT_MAX: assert property (AT_MAX_OUT == (COUNT_VALUE_OUT == 8'hff))
      else $error("max flag wrong");
   AST_REQ_MASKED: assert property (IRQ_REQ_OUT == (IRQ_FLAGS_OUT & IRQ_MASK_OUT))
      else $error("request not flags and mask");
   AST_MASK_WRITE: assert property (
      MASK_WR_IN |=> IRQ_MASK_OUT == $past(MASK_WR_DATA_IN))
      else $error("mask write not taken");
   AST_OVF_AT_WRAP: assert property (($past(RSTN_IN) && {WGM_HIGH_IN, WGM_LOW_IN} == 3'h0
      && $past(COUNT_VALUE_OUT) == 8'hff && COUNT_VALUE_OUT == 8'h00 && !$past(CNT_WR_IN))
      |-> IRQ_FLAGS_OUT[0]) else $error("wrap without overflow flag");
   // without ticks nothing can set a flag, so a clear must stick
   AST_CLEAR_IDLE: assert property (
      (idle && $past(idle) && (FLAG_CLR_IN | IRQ_ACK_IN) != 3'h0)
      |=> (IRQ_FLAGS_OUT & $past(FLAG_CLR_IN | IRQ_ACK_IN)) == 3'h0)
      else $error("flag not cleared");
   AST_OVERRIDE_LIVE: assert property (($past(RSTN_IN) && $stable(COM_A_IN))
      |-> PIN_OVERRIDE_A_OUT == (COM_A_IN != 2'b00)) else $error("override a wrong");
   cover property ($rose(IRQ_FLAGS_OUT[0]));
   cover property ($rose(IRQ_FLAGS_OUT[1]));
   cover property ($rose(AT_MAX_OUT));
endmodule // tmr8_checker
bind tmr8_timer tmr8_checker u_tmr8_checker (
   .REF_CLK_IN(REF_CLK_IN), .RSTN_IN(RSTN_IN), .POWER_OFF_BIT_IN(POWER_OFF_BIT_IN),
   .WGM_LOW_IN(WGM_LOW_IN), .WGM_HIGH_IN(WGM_HIGH_IN), .CLOCK_SOURCE_IN(CLOCK_SOURCE_IN),
   .COM_A_IN(COM_A_IN), .CNT_WR_IN(CNT_WR_IN), .WDATA_IN(WDATA_IN),
   .FLAG_CLR_IN(FLAG_CLR_IN), .IRQ_ACK_IN(IRQ_ACK_IN), .MASK_WR_DATA_IN(MASK_WR_DATA_IN),
   .MASK_WR_IN(MASK_WR_IN), .COUNT_VALUE_OUT(COUNT_VALUE_OUT), .IRQ_FLAGS_OUT(IRQ_FLAGS_OUT),
   .IRQ_MASK_OUT(IRQ_MASK_OUT), .IRQ_REQ_OUT(IRQ_REQ_OUT), .AT_MAX_OUT(AT_MAX_OUT),
   .AT_BOTTOM_OUT(AT_BOTTOM_OUT), .PIN_OVERRIDE_A_OUT(PIN_OVERRIDE_A_OUT)
);

// ===== testbench/tmr8_pin_model.sv
// port pad model behind output compare a
`timescale 1ns/1ps
module tmr8_pin_model (
   input  wire logic dir_out_in,  // pad direction, 1 drives
   input  wire logic port_val_in, // port latch value
   input  wire logic override_in, // timer owns the pad data
   input  wire logic oc_in,       // output compare state
   output logic      pin_out      // pad level
);
   // direction stays with the port; a released pad is pulled high
   assign pin_out = dir_out_in ? (override_in ? oc_in : port_val_in) : 1'b1;
endmodule // tmr8_pin_model

// ===== testbench/tb_top.sv
// self-checking bench for the 8-bit dual compare timer
`timescale 1ns/1ps
module tb_top;
   logic       clk, rstn, pwr, wgm_h, ext, cnt_wr, cmpa_wr, cmpb_wr, mask_wr, force_a;
   logic       force_b, ddr, pin, at_max, at_bot, oc_a, oc_b, ovr_a, ovr_b;
   logic [1:0] wgm_l, com_a, com_b;
   logic [2:0] cs, flag_clr, ack, flags, mask, req;
   logic [7:0] wdata, cnt, cmp_a, cmp_b, n8;
   int         err_total, checked;
   localparam int DIV [1:5] = '{1, 8, 64, 256, 1024};

   tmr8_timer u_tmr8_timer (.REF_CLK_IN(clk), .RSTN_IN(rstn), .POWER_OFF_BIT_IN(pwr),
      .WGM_LOW_IN(wgm_l), .WGM_HIGH_IN(wgm_h), .CLOCK_SOURCE_IN(cs), .COM_A_IN(com_a),
      .COM_B_IN(com_b), .FORCE_A_IN(force_a), .FORCE_B_IN(force_b), .EXT_COUNT_IN(ext),
      .CNT_WR_IN(cnt_wr), .CMPA_WR_IN(cmpa_wr), .CMPB_WR_IN(cmpb_wr), .WDATA_IN(wdata),
      .FLAG_CLR_IN(flag_clr), .IRQ_ACK_IN(ack), .MASK_WR_DATA_IN(wdata[2:0]),
      .MASK_WR_IN(mask_wr), .COUNT_VALUE_OUT(cnt), .COMPARE_A_OUT(cmp_a), .COMPARE_B_OUT(cmp_b),
      .IRQ_FLAGS_OUT(flags), .IRQ_MASK_OUT(mask), .IRQ_REQ_OUT(req), .AT_MAX_OUT(at_max),
      .AT_BOTTOM_OUT(at_bot), .COMPARE_OUT_A_OUT(oc_a), .COMPARE_OUT_B_OUT(oc_b),
      .PIN_OVERRIDE_A_OUT(ovr_a), .PIN_OVERRIDE_B_OUT(ovr_b));
   tmr8_pin_model u_tmr8_pin_model (.dir_out_in(ddr), .port_val_in(1'b0), .override_in(ovr_a),
      .oc_in(oc_a), .pin_out(pin));

   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   // inputs always move 2 ns after a rising edge
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #2;
   endtask
   // wide enough for the packed multi-field compares below
   task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
      checked++;
      if (seen !== exp) begin
         err_total++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic conclude;
      $display("checks %0d mismatches %0d", checked, err_total);
      if (err_total == 0 && checked > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   // one-cycle strobe: 0 count, 1 cmp a, 2 cmp b, 3 mask, 4 clear, 5/6 force, 7 ack
   // only the selected strobe is dropped, so back-to-back calls never drive one signal twice
   task automatic drive(input int k, input logic [2:0] v);
      case (k)
         0: cnt_wr = v[0];
         1: cmpa_wr = v[0];
         2: cmpb_wr = v[0];
         3: mask_wr = v[0];
         4: flag_clr = v;
         5: force_a = v[0];
         6: force_b = v[0];
         default: ack = v;
      endcase
   endtask
   task automatic strobe(input int k, input logic [7:0] d);
      wdata = d;
      drive(k, (k == 4 || k == 7) ? d[2:0] : 3'h1);
      cyc(1);
      drive(k, 3'h0);
   endtask
   // bounded wait for a counter value; a hang ends the run
   task automatic wait_cnt(input logic [7:0] v);
      int n;
      for (n = 0; n < 2000 && cnt !== v; n++) cyc(1);
      if (n == 2000) begin
         err_total++;
         $display("ERROR wait count expected %h seen %h", v, cnt);
         conclude;
      end
   endtask

   initial begin
      {rstn, pwr, wgm_h, ext, cnt_wr, cmpa_wr, cmpb_wr, mask_wr, force_a, force_b, ddr} = '0;
      {wgm_l, com_a, com_b, cs, flag_clr, ack, wdata} = '0;
      err_total = 0;
      checked = 0;
      cyc(8);
      chk("reset count", cnt, 8'h00);
      chk("reset state", {flags, mask, oc_a, oc_b}, 8'h00);
      rstn = 1'b1;
      cyc(1);
      chk("bottom", at_bot, 1);
      // stopped counters still take writes; stopped and powered-off counters never count
      strobe(0, 8'h5a);
      cyc(5);
      chk("stopped count", cnt, 8'h5a);
      pwr = 1'b1;
      cs = 3'h1;
      cyc(6);
      chk("power off count", cnt, 8'h5a);
      pwr = 1'b0;
      // write beats the running count, then wrap sets overflow
      strobe(0, 8'hfe);
      chk("write wins", cnt, 8'hfe);
      cyc(1);
      chk("max", {at_max, cnt}, 9'h1ff);
      cyc(1);
      chk("wrap", {flags, cnt}, 11'h100);
      cs = 3'h0;
      cyc(2);
      strobe(3, 8'h01);
      chk("masked req", req, 3'h1);
      strobe(4, 8'h07);
      chk("cleared", {flags, req}, 6'h00);
      // clear on compare a
      wgm_l = 2'h2;
      strobe(1, 8'h05);
      // compare readback is registered from the old value, one cycle behind
      cyc(1);
      chk("direct cmp a", cmp_a, 8'h05);
      strobe(0, 8'h00);
      cs = 3'h1;
      wait_cnt(8'h05);
      cyc(1);
      chk("ctc clear", cnt, 8'h00);
      chk("match a flag", flags[1], 1);
      cs = 3'h0;
      cyc(2);
      strobe(7, 8'h06);
      chk("serviced", flags[2:1], 2'h0);
      // a counter write equal to compare b hides that match
      wgm_l = 2'h0;
      strobe(2, 8'h10);
      strobe(0, 8'h10);
      chk("direct cmp b", cmp_b, 8'h10);
      cs = 3'h1;
      cyc(8);
      cs = 3'h0;
      cyc(2);
      chk("blocked b", flags[2], 0);
      strobe(0, 8'h0e);
      cs = 3'h1;
      cyc(8);
      cs = 3'h0;
      cyc(2);
      chk("match b flag", flags[2], 1);
      // preset outputs by force before the pad drives
      com_a = 2'h1;
      com_b = 2'h1;
      strobe(5, 8'h00);
      strobe(6, 8'h00);
      ddr = 1'b1;
      cyc(1);
      chk("force", {oc_a, oc_b, flags[1], cnt}, 11'h616);
      chk("override b", ovr_b, 1);
      chk("pin", pin, 1);
      com_a = 2'h0;
      cyc(1);
      chk("pin released", pin, 0);
      wgm_l = 2'h3;
      com_a = 2'h2;
      cyc(2);
      chk("kept state", oc_a, 1);
      strobe(5, 8'h00);
      // fast pwm: buffered compare a loads at top, set at bottom, clear at match
      strobe(1, 8'h80);
      cyc(1);
      chk("pwm no force", oc_a, 1);
      chk("buffer cmp a", cmp_a, 8'h80);
      strobe(0, 8'h00);
      cs = 3'h1;
      wait_cnt(8'h40);
      chk("old compare", oc_a, 0);
      wait_cnt(8'h00);
      wait_cnt(8'h40);
      chk("set at bottom", oc_a, 1);
      wait_cnt(8'h90);
      chk("new compare", oc_a, 0);
      cs = 3'h0;
      wgm_l = 2'h0;
      cyc(2);
      // prescaler rates: three periods give about three ticks
      for (int i = 1; i <= 5; i++) begin
         strobe(0, 8'h00);
         cs = 3'(i);
         cyc(3 * DIV[i]);
         cs = 3'h0;
         cyc(2);
         n8 = cnt;
         chk("rate", n8 >= 8'h02 && n8 <= 8'h04, 1);
      end
      // external input: rising then falling edge selection
      strobe(0, 8'h00);
      cs = 3'h7;
      ext = 1'b1;
      cyc(6);
      ext = 1'b0;
      cyc(6);
      chk("ext rise", cnt, 8'h01);
      cs = 3'h6;
      cyc(2);
      ext = 1'b1;
      cyc(6);
      chk("ext fall wait", cnt, 8'h01);
      ext = 1'b0;
      cyc(6);
      chk("ext fall", cnt, 8'h02);
      conclude;
   end
endmodule // tb_top
